// >>> common/wr_seq_pkg.sv
/*
  Shared constants and state types for the task-file write sequencer and its host end.
  Assumes one clock at 250 MHz shared by both ends.
*/
package wr_seq_pkg;
  // ----------------------------------------------------------------
  // Command opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_MULT     = 8'hC5;
  localparam logic [7:0] OP_WRITE_MULT_NE  = 8'hCD;
  localparam logic [7:0] OP_WRITE_SEC      = 8'h30;
  localparam logic [7:0] OP_WRITE_SEC_RTY  = 8'h31;
  localparam logic [7:0] OP_SET_MULT       = 8'hC6;
  // ----------------------------------------------------------------
  // Task-file register selects
  // ----------------------------------------------------------------
  localparam logic [2:0] TF_COUNT   = 3'h2;
  localparam logic [2:0] TF_ADDR_LO = 3'h3;
  localparam logic [2:0] TF_ADDR_MD = 3'h4;
  localparam logic [2:0] TF_ADDR_HI = 3'h5;
  localparam logic [2:0] TF_HEAD    = 3'h6;
  localparam logic [2:0] TF_CMD     = 3'h7;
  // ----------------------------------------------------------------
  // Field positions and fixed values
  // ----------------------------------------------------------------
  localparam int          HEAD_LBA_BIT = 6;
  localparam int          HEAD_DRV_BIT = 4;
  localparam int          ST_BSY_BIT   = 7;
  localparam int          ST_DRQ_BIT   = 3;
  localparam int          ST_ERR_BIT   = 0;
  localparam int          ER_ABRT_BIT  = 2;
  localparam int          ER_MEDIA_BIT = 6;
  localparam logic [7:0]  MAX_BLOCK    = 8'h01;
  localparam logic [8:0]  MAX_SECTORS  = 9'h100;
  localparam int          SECTOR_BYTES = 512;
  localparam int          SECTOR_WORDS = SECTOR_BYTES / 2;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_NS       = 4;
  localparam int          BSY_MAX_NS   = 400;
  localparam int          BSY_MAX_CYC  = BSY_MAX_NS / CLK_NS;
  // ----------------------------------------------------------------
  // Host software register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0]  H_CMD    = 8'h00;
  localparam logic [7:0]  H_LBA    = 8'h04;
  localparam logic [7:0]  H_COUNT  = 8'h08;
  localparam logic [7:0]  H_STATUS = 8'h0C;
  localparam logic [7:0]  H_RESULT = 8'h10;
  localparam logic [7:0]  H_RESID  = 8'h14;
  localparam int          H_LBA_MODE_BIT = 28;
  localparam int          H_DRV_BIT      = 29;
  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {D_IDLE, D_ACCEPT, D_XFER, D_PROG, D_WAIT} dev_state_t;
  typedef enum logic [1:0] {H_IDLE, H_TF, H_RUN} host_state_t;
endpackage

// >>> common/task_file_if.sv
/*
  Task-file link between the host controller and the storage device.
  Assumes both ends run on the clock given to the interface.
*/
`timescale 1ns/1ns
interface task_file_if (
  input wire logic clk
);
  logic        tf_wr;      // Task-file register write
  logic [2:0]  tf_sel;     // Register select
  logic [7:0]  tf_wdata;   // Register write data
  logic        data_wr;    // Sector data word write
  logic [15:0] data_word;  // Sector data word
  logic        status_rd;  // Status read, clears interrupt
  logic [7:0]  status;     // Busy, data request, error
  logic [7:0]  error;      // Error register
  logic [7:0]  count_rd;   // Transfer length readback
  logic [27:0] lba_rd;     // Address readback
  logic [7:0]  head_rd;    // Device select and head readback
  logic        intrq;      // Interrupt level
  logic [7:0]  max_block;  // Identify: largest block size

  modport device_end (
    input  tf_wr, tf_sel, tf_wdata, data_wr, data_word, status_rd,
    output status, error, count_rd, lba_rd, head_rd, intrq, max_block
  );
  modport host_end (
    output tf_wr, tf_sel, tf_wdata, data_wr, data_word, status_rd,
    input  status, error, count_rd, lba_rd, head_rd, intrq, max_block
  );
endinterface

// >>> hdl/sector_word_counter.sv
/*
  Counts data words of one sector and flags the last one.
  Assumes inc never rises while clr is high.
*/
`timescale 1ns/1ns
module sector_word_counter #(
  parameter int WORDS = 256
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic clr,
  input  wire logic inc,
  output logic      last
);
  logic [$clog2(WORDS)-1:0] cnt_r;

  // Last word of the sector in this cycle
  assign last = inc && (cnt_r == ($clog2(WORDS))'(WORDS - 1));

  // Word count, wraps at sector end
  always_ff @(posedge clk) begin
    if (rst || clr || last) begin
      cnt_r <= '0;
    end else if (inc) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule // sector_word_counter

// >>> hdl/ata_write_command_sequencer.sv
/*
  Device end: executes the sector write, the block write and the
  block write without erase, plus the block size setup.
  Assumes a media back end that programs one sector per request.
*/
// The register offsets and the strobed register port were chosen for this implementation.
// Notes on behaviour
// - busy within 400 ns of block write
// - one interrupt per block, not per sector
// - data request qualifies only block starts
// - host sets block size before block writes
// - transfer length counts sectors, not blocks
// - full blocks first, then one partial block
// - abort block write when block mode unset
// - error stops at failing sector, no more
// - interrupt with data request at block start
// - after error: failing address, residual count
// - only block size one, shown in identify
// - head byte bits and address byte layout
// - no-erase block write skips implied erase
// - host should pre-erase before no-erase write
// - 1 to 256 sectors, zero means 256
// - writing starts at the task-file address
// - first sector: busy, request, no interrupt
// - host sends data only after busy clears
// - between sectors busy, then request with interrupt
// - after last sector busy until done, interrupt
// - error leaves failing sector address
// - host reads address and error after error
// - each sector is 512 bytes
`timescale 1ns/1ns
module ata_write_command_sequencer (
  input  wire logic        clk,
  input  wire logic        rst,
  task_file_if.device_end  tf,
  output logic [15:0]      media_word,
  output logic             media_word_valid,
  output logic             media_prog_req,
  output logic [27:0]      media_lba,
  output logic             media_erase,
  input  wire logic        media_done,
  input  wire logic        media_fail
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    wr_seq_pkg::dev_state_t st;
    logic [7:0]  op;
    logic        lba_mode;
    logic        drv;
    logic [27:0] lba;
    logic [7:0]  count;
    logic [7:0]  error;
    logic        err;
    logic        bsy;
    logic        drq;
    logic        intrq;
    logic        mult_en;
    logic [7:0]  blk;
    logic [8:0]  blk_cur;
    logic [8:0]  blk_left;
    logic [8:0]  remain;
    logic        erase;
    logic [15:0] word;
    logic        word_valid;
    logic        prog_req;
  } dev_t;

  dev_t s_r;
  dev_t s_nxt;
  logic sector_last;
  logic is_mult;
  logic is_wr;
  logic [8:0] req_len;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  assign is_mult = (s_r.op == wr_seq_pkg::OP_WRITE_MULT) ||
                   (s_r.op == wr_seq_pkg::OP_WRITE_MULT_NE);
  assign is_wr   = (s_r.op == wr_seq_pkg::OP_WRITE_SEC) ||
                   (s_r.op == wr_seq_pkg::OP_WRITE_SEC_RTY);
  // Zero length asks for the maximum
  assign req_len = (s_r.count == 8'h00) ? wr_seq_pkg::MAX_SECTORS
                                        : {1'b0, s_r.count};

  // Word counting for one sector
  sector_word_counter #(
    .WORDS (wr_seq_pkg::SECTOR_WORDS)
  ) i_sector_word_counter (
    .clk  (clk),
    .rst  (rst),
    .clr  (s_r.st == wr_seq_pkg::D_ACCEPT),
    .inc  ((s_r.st == wr_seq_pkg::D_XFER) && tf.data_wr),
    .last (sector_last)
  );

  // Smaller of block size and sectors left
  function automatic logic [8:0] first_blk(input logic [8:0] b, input logic [8:0] r);
    first_blk = (b < r) ? b : r;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.word_valid = 1'b0;
    s_nxt.prog_req = 1'b0;
    // Status read clears, any event below wins
    if (tf.status_rd) begin
      s_nxt.intrq = 1'b0;
    end
    unique case (s_r.st)
      wr_seq_pkg::D_IDLE: begin
        if (tf.tf_wr) begin
          unique case (tf.tf_sel)
            wr_seq_pkg::TF_COUNT:   s_nxt.count = tf.tf_wdata;
            wr_seq_pkg::TF_ADDR_LO: s_nxt.lba[7:0] = tf.tf_wdata;
            wr_seq_pkg::TF_ADDR_MD: s_nxt.lba[15:8] = tf.tf_wdata;
            wr_seq_pkg::TF_ADDR_HI: s_nxt.lba[23:16] = tf.tf_wdata;
            wr_seq_pkg::TF_HEAD: begin
              s_nxt.lba[27:24] = tf.tf_wdata[3:0];
              s_nxt.lba_mode = tf.tf_wdata[wr_seq_pkg::HEAD_LBA_BIT];
              s_nxt.drv = tf.tf_wdata[wr_seq_pkg::HEAD_DRV_BIT];
            end
            wr_seq_pkg::TF_CMD: begin
              s_nxt.op = tf.tf_wdata;
              s_nxt.bsy = 1'b1;
              s_nxt.err = 1'b0;
              s_nxt.error = 8'h00;
              s_nxt.st = wr_seq_pkg::D_ACCEPT;
            end
            default: ;
          endcase
        end
      end
      wr_seq_pkg::D_ACCEPT: begin
        s_nxt.bsy = 1'b0;
        s_nxt.st = wr_seq_pkg::D_IDLE;
        if (s_r.op == wr_seq_pkg::OP_SET_MULT) begin
          // Zero disables block mode, above the limit aborts
          s_nxt.intrq = 1'b1;
          if (s_r.count == 8'h00) begin
            s_nxt.mult_en = 1'b0;
          end else if (s_r.count <= wr_seq_pkg::MAX_BLOCK) begin
            s_nxt.mult_en = 1'b1;
            s_nxt.blk = s_r.count;
          end else begin
            s_nxt.err = 1'b1;
            s_nxt.error[wr_seq_pkg::ER_ABRT_BIT] = 1'b1;
          end
        end else if ((is_mult && s_r.mult_en) || is_wr) begin
          // Single sector writes behave as blocks of one
          s_nxt.blk_cur = is_mult ? {1'b0, s_r.blk} : 9'h001;
          s_nxt.remain = req_len;
          s_nxt.blk_left = first_blk(is_mult ? {1'b0, s_r.blk} : 9'h001, req_len);
          s_nxt.erase = (s_r.op != wr_seq_pkg::OP_WRITE_MULT_NE);
          s_nxt.drq = 1'b1;
          s_nxt.intrq = is_mult;
          s_nxt.st = wr_seq_pkg::D_XFER;
        end else begin
          // Block mode unset, disabled, or opcode not handled
          s_nxt.err = 1'b1;
          s_nxt.error[wr_seq_pkg::ER_ABRT_BIT] = 1'b1;
          s_nxt.intrq = 1'b1;
        end
      end
      wr_seq_pkg::D_XFER: begin
        if (tf.data_wr) begin
          s_nxt.word = tf.data_word;
          s_nxt.word_valid = 1'b1;
          if (sector_last) begin
            s_nxt.bsy = 1'b1;
            s_nxt.drq = 1'b0;
            s_nxt.st = wr_seq_pkg::D_PROG;
          end
        end
      end
      wr_seq_pkg::D_PROG: begin
        s_nxt.prog_req = 1'b1;
        s_nxt.st = wr_seq_pkg::D_WAIT;
      end
      wr_seq_pkg::D_WAIT: begin
        if (media_done) begin
          if (media_fail) begin
            // Stop here, address kept, residual reported
            s_nxt.err = 1'b1;
            s_nxt.error[wr_seq_pkg::ER_MEDIA_BIT] = 1'b1;
            s_nxt.count = s_r.remain[7:0];
            s_nxt.bsy = 1'b0;
            s_nxt.intrq = 1'b1;
            s_nxt.st = wr_seq_pkg::D_IDLE;
          end else if (s_r.remain == 9'h001) begin
            // Command complete, last address kept
            s_nxt.remain = 9'h000;
            s_nxt.count = 8'h00;
            s_nxt.bsy = 1'b0;
            s_nxt.intrq = 1'b1;
            s_nxt.st = wr_seq_pkg::D_IDLE;
          end else begin
            s_nxt.lba = s_r.lba + 28'h0000001;
            s_nxt.remain = s_r.remain - 9'h001;
            s_nxt.bsy = 1'b0;
            s_nxt.drq = 1'b1;
            s_nxt.st = wr_seq_pkg::D_XFER;
            if (s_r.blk_left == 9'h001) begin
              // New block or final partial block
              s_nxt.blk_left = first_blk(s_r.blk_cur, s_r.remain - 9'h001);
              s_nxt.intrq = 1'b1;
            end else begin
              // Inside a block: no new qualification
              s_nxt.blk_left = s_r.blk_left - 9'h001;
            end
          end
        end
      end
      default: s_nxt.st = wr_seq_pkg::D_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
      s_r.st <= wr_seq_pkg::D_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign tf.status = {s_r.bsy, 3'b000, s_r.drq, 2'b00, s_r.err};
  assign tf.error = s_r.error;
  assign tf.count_rd = s_r.count;
  assign tf.lba_rd = s_r.lba;
  assign tf.head_rd = {1'b1, s_r.lba_mode, 1'b1, s_r.drv, s_r.lba[27:24]};
  assign tf.intrq = s_r.intrq;
  assign tf.max_block = wr_seq_pkg::MAX_BLOCK;
  assign media_word = s_r.word;
  assign media_word_valid = s_r.word_valid;
  assign media_prog_req = s_r.prog_req;
  assign media_lba = s_r.lba;
  assign media_erase = s_r.erase;
endmodule // ata_write_command_sequencer

// >>> hdl/ata_write_host.sv
/*
  Host end: software registers on a plain port drive the task file,
  feed sector data from a stream and collect the outcome.
  Assumes software sets block size before block writes.
*/
`timescale 1ns/1ns
module ata_write_host (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  sw_addr,
  input  wire logic [31:0] sw_wdata,
  input  wire logic        sw_we,
  input  wire logic        sw_re,
  output logic [31:0]      sw_rdata,
  input  wire logic [15:0] word_in,
  input  wire logic        word_valid,
  output logic             word_ready,
  task_file_if.host_end    tf
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    wr_seq_pkg::host_state_t st;
    logic [7:0]  op;
    logic [29:0] lba;
    logic [7:0]  count;
    logic [2:0]  step;
    logic        busy;
    logic        done;
    logic [7:0]  error;
    logic [7:0]  stat;
    logic [27:0] res_lba;
    logic [7:0]  res_count;
    logic [31:0] rdata;
    logic        tf_wr;
    logic [2:0]  tf_sel;
    logic [7:0]  tf_wdata;
    logic        data_wr;
    logic [15:0] data_word;
    logic        status_rd;
  } host_t;

  host_t s_r;
  host_t s_nxt;

  // Data only while requested and not busy, one word in flight
  assign word_ready = (s_r.st == wr_seq_pkg::H_RUN) && tf.status[wr_seq_pkg::ST_DRQ_BIT] &&
                      !tf.status[wr_seq_pkg::ST_BSY_BIT] && !s_r.data_wr;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.tf_wr = 1'b0;
    s_nxt.data_wr = 1'b0;
    s_nxt.status_rd = 1'b0;
    s_nxt.rdata = 32'h00000000;
    // Software writes, command only while idle
    if (sw_we) begin
      unique case (sw_addr)
        wr_seq_pkg::H_LBA:   s_nxt.lba = sw_wdata[29:0];
        wr_seq_pkg::H_COUNT: s_nxt.count = sw_wdata[7:0];
        wr_seq_pkg::H_CMD: begin
          if (s_r.st == wr_seq_pkg::H_IDLE) begin
            s_nxt.op = sw_wdata[7:0];
            s_nxt.busy = 1'b1;
            s_nxt.done = 1'b0;
            s_nxt.step = 3'h0;
            s_nxt.st = wr_seq_pkg::H_TF;
          end
        end
        default: ;
      endcase
    end
    // Software reads, data in next cycle
    if (sw_re) begin
      unique case (sw_addr)
        wr_seq_pkg::H_STATUS: s_nxt.rdata = {14'h0000, s_r.done, s_r.busy, s_r.error, s_r.stat};
        wr_seq_pkg::H_RESULT: s_nxt.rdata = {4'h0, s_r.res_lba};
        wr_seq_pkg::H_RESID:  s_nxt.rdata = {24'h000000, s_r.res_count};
        default: s_nxt.rdata = 32'h00000000;
      endcase
    end
    unique case (s_r.st)
      wr_seq_pkg::H_IDLE: ;
      wr_seq_pkg::H_TF: begin
        // Load count, address bytes, head, then command
        s_nxt.tf_wr = 1'b1;
        s_nxt.step = s_r.step + 3'h1;
        unique case (s_r.step)
          3'h0: begin s_nxt.tf_sel = wr_seq_pkg::TF_COUNT; s_nxt.tf_wdata = s_r.count; end
          3'h1: begin s_nxt.tf_sel = wr_seq_pkg::TF_ADDR_LO; s_nxt.tf_wdata = s_r.lba[7:0]; end
          3'h2: begin s_nxt.tf_sel = wr_seq_pkg::TF_ADDR_MD; s_nxt.tf_wdata = s_r.lba[15:8]; end
          3'h3: begin s_nxt.tf_sel = wr_seq_pkg::TF_ADDR_HI; s_nxt.tf_wdata = s_r.lba[23:16]; end
          3'h4: begin
            s_nxt.tf_sel = wr_seq_pkg::TF_HEAD;
            s_nxt.tf_wdata = {1'b1, s_r.lba[wr_seq_pkg::H_LBA_MODE_BIT], 1'b1,
                              s_r.lba[wr_seq_pkg::H_DRV_BIT], s_r.lba[27:24]};
          end
          default: begin
            s_nxt.tf_sel = wr_seq_pkg::TF_CMD;
            s_nxt.tf_wdata = s_r.op;
            s_nxt.st = wr_seq_pkg::H_RUN;
          end
        endcase
      end
      wr_seq_pkg::H_RUN: begin
        if (word_valid && word_ready) begin
          s_nxt.data_wr = 1'b1;
          s_nxt.data_word = word_in;
        end
        // Acknowledge each interrupt; quiet device means finished
        if (tf.intrq && !s_r.status_rd) begin
          s_nxt.status_rd = 1'b1;
          if (!tf.status[wr_seq_pkg::ST_BSY_BIT] && !tf.status[wr_seq_pkg::ST_DRQ_BIT]) begin
            s_nxt.stat = tf.status;
            s_nxt.error = tf.error;
            s_nxt.res_lba = tf.lba_rd;
            s_nxt.res_count = tf.count_rd;
            s_nxt.busy = 1'b0;
            s_nxt.done = 1'b1;
            s_nxt.st = wr_seq_pkg::H_IDLE;
          end
        end
      end
      default: s_nxt.st = wr_seq_pkg::H_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
      s_r.st <= wr_seq_pkg::H_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sw_rdata = s_r.rdata;
  assign tf.tf_wr = s_r.tf_wr;
  assign tf.tf_sel = s_r.tf_sel;
  assign tf.tf_wdata = s_r.tf_wdata;
  assign tf.data_wr = s_r.data_wr;
  assign tf.data_word = s_r.data_word;
  assign tf.status_rd = s_r.status_rd;
endmodule // ata_write_host

// >>> tb/wr_seq_properties.sv
/*
  Checker for the task-file link between host end and device end.
  Assumes one clock and synchronous active-high reset.
*/
`timescale 1ns/1ns
module wr_seq_properties (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       tf_wr,
  input wire logic [2:0] tf_sel,
  input wire logic [7:0] tf_wdata,
  input wire logic       data_wr,
  input wire logic [7:0] status,
  input wire logic       intrq,
  input wire logic [7:0] max_block
);
  // ----------------------------------------------------------------
  // Command tracking
  // ----------------------------------------------------------------
  logic       cmd_go;
  logic [7:0] word_cnt_r;
  logic       first_r;
  logic [7:0] op_r;
  assign cmd_go = tf_wr && tf_sel == 3'h7 && !status[7] && !status[3];
  // Words per sector, first data request, last opcode
  always_ff @(posedge clk) begin
    if (rst) begin
      word_cnt_r <= 8'h00;
      first_r    <= 1'b0;
      op_r       <= 8'h00;
    end else if (cmd_go) begin
      word_cnt_r <= 8'h00;
      first_r    <= 1'b1;
      op_r       <= tf_wdata;
    end else if (data_wr) begin
      word_cnt_r <= word_cnt_r + 8'h01;
      first_r    <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_busy_on_cmd: assert property (cmd_go |-> ##[1:100] status[7])
    else $error("busy late after command");
  a_busy_drq_excl: assert property (!(status[7] && status[3]))
    else $error("busy and data request together");
  a_data_needs_drq: assert property (data_wr |-> status[3] && !status[7])
    else $error("data word outside data phase");
  a_sector_end_busy: assert property (data_wr && word_cnt_r == 8'hFF |=> status[7] && !status[3])
    else $error("no busy after last word of sector");
  a_first_drq_quiet: assert property ($rose(status[3]) && first_r && (op_r == 8'h30 || op_r == 8'h31) |-> !intrq)
    else $error("interrupt on first sector request");
  a_block_drq_int: assert property ($rose(status[3]) && (op_r == 8'hC5 || op_r == 8'hCD) |-> intrq)
    else $error("block start without interrupt");
  a_next_drq_int: assert property ($rose(status[3]) && !first_r |-> intrq)
    else $error("later request without interrupt");
  a_done_int: assert property ($fell(status[7]) && !status[3] |-> intrq)
    else $error("completion without interrupt");
  a_block_one: assert property (max_block == 8'h01)
    else $error("largest block size not one");
endmodule // wr_seq_properties

// >>> tb/ata_write_command_sequencer_bench.sv
/*
  Bench joining host end and device end, with a media responder.
  Assumes the host software port and task-file link of the package.
*/
`timescale 1ns/1ns
module ata_write_command_sequencer_bench;
  logic        clk = 1'b0, rst, sw_we, sw_re, word_valid, media_done, media_fail;
  logic [7:0]  sw_addr;
  logic [31:0] sw_wdata, sw_rdata, base_lba, d;
  logic [15:0] word_in = 16'h0000, media_word, exp_word = 16'h0000;
  logic        word_ready, media_word_valid, media_prog_req, media_erase, exp_erase;
  logic [27:0] media_lba;
  logic [7:0]  ops [4] = '{8'h30, 8'h31, 8'hC5, 8'hCD};
  int          bad_count, samples_checked, prog_cnt, fail_idx, delay, wcnt;
  task_file_if tf_bus (.clk(clk));
  ata_write_command_sequencer i_ata_write_command_sequencer (.clk(clk), .rst(rst),
    .tf(tf_bus.device_end), .media_word(media_word), .media_word_valid(media_word_valid),
    .media_prog_req(media_prog_req), .media_lba(media_lba), .media_erase(media_erase),
    .media_done(media_done), .media_fail(media_fail));
  ata_write_host i_ata_write_host (.clk(clk), .rst(rst), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_we(sw_we), .sw_re(sw_re), .sw_rdata(sw_rdata),
    .word_in(word_in), .word_valid(word_valid), .word_ready(word_ready),
    .tf(tf_bus.host_end));
  wr_seq_properties i_wr_seq_properties (.clk(clk), .rst(rst), .tf_wr(tf_bus.tf_wr),
    .tf_sel(tf_bus.tf_sel), .tf_wdata(tf_bus.tf_wdata), .data_wr(tf_bus.data_wr),
    .status(tf_bus.status), .intrq(tf_bus.intrq), .max_block(tf_bus.max_block));
  // ----------------------------------------------------------------
  // Clock, data stream, media responder
  // ----------------------------------------------------------------
  always #2 clk = ~clk;
  always @(posedge clk) if (word_ready) word_in <= word_in + 16'h0001;
  // Answers each program request four cycles later
  always @(posedge clk) begin
    media_done <= 1'b0;
    media_fail <= 1'b0;
    if (delay > 0) delay <= delay - 1;
    // Program count restarts with every command
    if (tf_bus.tf_wr && tf_bus.tf_sel == wr_seq_pkg::TF_CMD) prog_cnt <= 0;
    // Words reach the media in stream order
    if (media_word_valid) begin
      chk({16'h0, media_word}, {16'h0, exp_word});
      exp_word <= exp_word + 16'h0001;
      wcnt     <= wcnt + 1;
    end
    if (media_prog_req) begin
      chk({4'h0, media_lba}, base_lba + prog_cnt);
      chk({31'h0, media_erase}, {31'h0, exp_erase});
      chk(wcnt, wr_seq_pkg::SECTOR_WORDS);
      wcnt  <= 0;
      delay <= 4;
    end else if (delay == 1) begin
      media_done <= 1'b1;
      media_fail <= (prog_cnt == fail_idx);
      prog_cnt   <= prog_cnt + 1;
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    sw_addr  <= a;
    sw_wdata <= v;
    sw_we    <= 1'b1;
    @(posedge clk);
    sw_we    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    sw_addr <= a;
    sw_re   <= 1'b1;
    @(posedge clk);
    sw_re   <= 1'b0;
    #1 v = sw_rdata;
  endtask
  // Loads address and count, issues opcode, polls until idle
  task automatic run_cmd(input logic [7:0] op, input logic [27:0] lba, input logic [7:0] cnt,
                         input int fail);
    int n;
    n         = 0;
    base_lba  = {4'h0, lba};
    fail_idx  = fail;
    exp_erase = (op != 8'hCD);
    wr(wr_seq_pkg::H_LBA, {4'h1, lba});
    wr(wr_seq_pkg::H_COUNT, {24'h0, cnt});
    wr(wr_seq_pkg::H_CMD, {24'h0, op});
    repeat (10) @(posedge clk);
    rd(wr_seq_pkg::H_STATUS, d);
    while (d[16] !== 1'b0 && n < 3000) begin
      rd(wr_seq_pkg::H_STATUS, d);
      n++;
    end
    if (n >= 3000) chk(32'h1, 32'h0);
  endtask
  task automatic close_out;
    if (bad_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {sw_we, sw_re, sw_addr, sw_wdata} = '0;
    {bad_count, samples_checked} = '0;
    rst = 1'b1;
    word_valid = 1'b1;
    fail_idx = -1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(wr_seq_pkg::H_STATUS, d);
    chk(d, 32'h0);
    run_cmd(8'hC5, 28'h0000010, 8'h01, -1);
    chk({31'h0, d[10]}, 32'h1);
    chk(prog_cnt, 0);
    run_cmd(wr_seq_pkg::OP_SET_MULT, 28'h0, 8'h02, -1);
    chk({31'h0, d[10]}, 32'h1);
    run_cmd(wr_seq_pkg::OP_SET_MULT, 28'h0, 8'h01, -1);
    chk({24'h0, d[15:8]}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      run_cmd(ops[i], 28'h3ABCD10 + 28'(i * 16), 8'h02, -1);
      chk(prog_cnt, 2);
      rd(wr_seq_pkg::H_RESULT, d);
      chk(d, base_lba + 1);
      rd(wr_seq_pkg::H_RESID, d);
      chk(d, 32'h0);
      chk({24'h0, tf_bus.head_rd}, 32'hE3);
    end
    run_cmd(8'hC5, 28'h0000100, 8'h03, 1);
    chk({31'h0, d[14]}, 32'h1);
    chk(prog_cnt, 2);
    rd(wr_seq_pkg::H_RESULT, d);
    chk(d, base_lba + 1);
    rd(wr_seq_pkg::H_RESID, d);
    chk(d, 32'h2);
    run_cmd(8'hCD, 28'h0000200, 8'h00, 1);
    rd(wr_seq_pkg::H_RESID, d);
    chk(d, 32'hFF);
    // Block mode switched off again: block write refused
    run_cmd(wr_seq_pkg::OP_SET_MULT, 28'h0, 8'h00, -1);
    run_cmd(8'hCD, 28'h0000300, 8'h01, -1);
    chk({31'h0, d[10]}, 32'h1);
    chk(prog_cnt, 0);
    close_out;
  end
  // Watchdog
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    close_out;
  end
endmodule // ata_write_command_sequencer_bench
